/* File: rtl/bp_regs_pkg.sv */
// Purpose: constants for the backplane status and board control bank
// Assumes: byte-wide host i/o port space, 16-bit port addresses
// Notes:   bit positions and reset values used by the register bank, which passes them to the helper modules
package bp_regs_pkg;

    // port addresses
    localparam logic [15:0] ADDR_BACKPLANE_STATUS = 16'h0281;
    localparam logic [15:0] ADDR_GENERAL_CONTROL  = 16'h0282;
    localparam logic [15:0] ADDR_BOARD_CONTROL    = 16'h0283;

    // backplane_status fields
    localparam int BIT_BUS_SPEED   = 7;
    localparam int BIT_SLOT_KIND   = 3;
    localparam int BIT_HOT_SWAP    = 2;
    localparam int BIT_SUPPLY_FAIL = 1;
    localparam int BIT_SUPPLY_DRT  = 0;

    // general_control fields
    localparam int BIT_VIDEO_HI    = 7;
    localparam int BIT_VIDEO_LO    = 6;
    localparam int BIT_FLASH_SEL   = 5;

    // board_control fields
    localparam int BIT_SATA_RUN    = 7;
    localparam int BIT_IGFX_EN     = 6;
    localparam int BIT_TPM_EN      = 5;
    localparam int BIT_RST_GATE    = 4;
    localparam int BIT_SERIAL_RT   = 2;

    // video mode encodings
    localparam logic [1:0] VIDEO_AUTO  = 2'h0;
    localparam logic [1:0] VIDEO_FRONT = 2'h1;
    localparam logic [1:0] VIDEO_REAR  = 2'h2;
    localparam logic [1:0] VIDEO_OFF   = 2'h3;

    // reset values
    localparam logic [1:0] RST_VIDEO_MODE = VIDEO_FRONT;
    localparam logic       RST_FLASH_SEL  = 1'h0;
    localparam logic       RST_SATA_RUN   = 1'h1;
    localparam logic       RST_IGFX_EN    = 1'h1;
    localparam logic       RST_TPM_EN     = 1'h1;
    localparam logic       RST_RST_GATE   = 1'h1;
    localparam logic       RST_SERIAL_RT  = 1'h0;
    localparam logic       RST_PIN_LEVEL  = 1'h1;
    localparam logic       RST_PRST_N     = 1'h1;

    // serial routing encodings
    localparam logic SERIAL_REAR = 1'h0;
    localparam logic SERIAL_EXT  = 1'h1;

endpackage : bp_regs_pkg

/* File: rtl/pin_sync.sv */
// Purpose: three-stage synchroniser for one asynchronous pin
// Assumes: pin may change at any time relative to core_clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter logic RST_VAL = 1'h1
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // pin and result
    input  wire logic pin_in,
    output var  logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // s1 feeds s2 only; the agreement check sees s2 and s3
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_q    <= RST_VAL;
            s2_q    <= RST_VAL;
            s3_q    <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

endmodule : pin_sync
`default_nettype wire

/* File: rtl/ctl_bit.sv */
// Purpose: one host-writable control bit with its own reset value
// Assumes: write strobe and data come from the core_clk domain
// Notes:   used for every single-bit r/w control field except the serial route
`timescale 1ns/1ps
`default_nettype none
module ctl_bit #(
    parameter logic RST_VAL = 1'h0
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // write side
    input  wire logic wr_en,
    input  wire logic wr_val,
    // stored value
    output var  logic bit_q
);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bit_q <= RST_VAL;
        end else if (wr_en) begin
            bit_q <= wr_val;
        end
    end

endmodule : ctl_bit
`default_nettype wire

/* File: rtl/backplane_status_board_control_regs.sv */
// Purpose: host i/o register bank for backplane status and board control
// Assumes: byte i/o reads and writes as one-cycle strobes on core_clk
// Notes:   read data appears one cycle after the read strobe; control
//          outputs other than video mode lag their register bits by one cycle, status pins
//          by three to four cycles of synchroniser delay
//
// What this block does
// - status bit 7 shows bus speed pin
// - status bit 3 shows slot kind pin
// - status bit 2 shows hot swap pin
// - status bit 1 shows supply fail pin
// - status bit 0 shows supply derate pin
// - general bits 7:6 video mode, reset front
// - general bit 5 update flash select, reset 0
// - board bit 7 sata module run control
// - board bit 6 read-only graphics enabled, reset 1
// - board bit 5 tpm enable, reset 1
// - board bit 4 gates backplane reset, peripheral slot
// - board bit 2 serial route rear or extension
// - serial route reset follows board variant strap
`timescale 1ns/1ps
`default_nettype none
module backplane_status_board_control_regs (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // host i/o port access
    input  wire logic [15:0] io_addr,
    input  wire logic        io_rd_en,
    input  wire logic        io_wr_en,
    input  wire logic [7:0]  io_wdata,
    output var  logic [7:0]  io_rdata_q,
    output var  logic        io_rd_ack_q,
    output var  logic        io_rd_hit_q,
    // backplane pins
    input  wire logic        bus_speed_pin,
    input  wire logic        slot_kind_pin,
    input  wire logic        hot_swap_event_pin,
    input  wire logic        supply_fail_pin,
    input  wire logic        supply_derate_pin,
    input  wire logic        backplane_rst_pin_n,
    // board straps and state
    input  wire logic        front_io_variant,
    input  wire logic        igfx_enabled_pin,
    // control outputs
    output var  logic [1:0]  video_mode_field_q,
    output var  logic        update_flash_select_q,
    output var  logic        sata_module_run_q,
    output var  logic        tpm_enable_q,
    output var  logic        backplane_reset_gate_q,
    output var  logic        serial_route_select_q,
    output var  logic        board_reset_req_q
);

    // synchronised pin levels
    logic bus_speed_flag;
    logic slot_kind_flag;
    logic hot_swap_event_flag;
    logic supply_fail_flag;
    logic supply_derate_flag;
    logic bp_rst_n_sync;
    logic front_io_sync;
    logic igfx_enabled;

    // decode wires
    logic hit_status;
    logic hit_general;
    logic hit_board;
    logic wr_general;
    logic wr_board;
    logic [7:0] status_byte;
    logic [7:0] general_byte;
    logic [7:0] board_byte;
    logic [7:0] rdata_d;
    logic       hit_any;

    // control state
    logic [1:0] video_mode_d;
    logic       flash_sel;
    logic       sata_run;
    logic       tpm_en;
    logic       rst_gate;
    logic       serial_rt_q;
    logic       serial_rt_d;
    logic       strap_load_q;
    logic       strap_hold_d;
    logic       board_rst_d;

    // pins rest high between events, so the chains reset to the idle level
    // and a release of reset shows no false event on the status bits
    // backplane pins, each through three stages
    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PIN_LEVEL)) u_sync_speed (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (bus_speed_pin),
        .level_q  (bus_speed_flag)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PIN_LEVEL)) u_sync_slot (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (slot_kind_pin),
        .level_q  (slot_kind_flag)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PIN_LEVEL)) u_sync_enum (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (hot_swap_event_pin),
        .level_q  (hot_swap_event_flag)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PIN_LEVEL)) u_sync_fail (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (supply_fail_pin),
        .level_q  (supply_fail_flag)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PIN_LEVEL)) u_sync_derate (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (supply_derate_pin),
        .level_q  (supply_derate_flag)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_PRST_N)) u_sync_prst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (backplane_rst_pin_n),
        .level_q  (bp_rst_n_sync)
    );

    // board strap and graphics level are asynchronous pins as well
    pin_sync #(.RST_VAL(bp_regs_pkg::RST_SERIAL_RT)) u_sync_strap (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (front_io_variant),
        .level_q  (front_io_sync)
    );

    pin_sync #(.RST_VAL(bp_regs_pkg::RST_IGFX_EN)) u_sync_igfx (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (igfx_enabled_pin),
        .level_q  (igfx_enabled)
    );

    // address decode
    // full 16-bit compare: aliases higher in port space must not hit
    assign hit_status  = (io_addr == bp_regs_pkg::ADDR_BACKPLANE_STATUS);
    assign hit_general = (io_addr == bp_regs_pkg::ADDR_GENERAL_CONTROL);
    assign hit_board   = (io_addr == bp_regs_pkg::ADDR_BOARD_CONTROL);
    assign hit_any     = hit_status | hit_general | hit_board;

    // a read and write in one cycle is treated as a write plus a read
    // (the read returns the old value, the write lands at the same edge)
    assign wr_general  = io_wr_en & hit_general;
    assign wr_board    = io_wr_en & hit_board;

    // general_control fields
    assign video_mode_d = wr_general
        ? io_wdata[bp_regs_pkg::BIT_VIDEO_HI:bp_regs_pkg::BIT_VIDEO_LO]
        : video_mode_field_q;

    ctl_bit #(.RST_VAL(bp_regs_pkg::RST_FLASH_SEL)) u_flash_sel (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_general),
        .wr_val   (io_wdata[bp_regs_pkg::BIT_FLASH_SEL]),
        .bit_q    (flash_sel)
    );

    // board_control writable fields
    ctl_bit #(.RST_VAL(bp_regs_pkg::RST_SATA_RUN)) u_sata_run (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_board),
        .wr_val   (io_wdata[bp_regs_pkg::BIT_SATA_RUN]),
        .bit_q    (sata_run)
    );

    ctl_bit #(.RST_VAL(bp_regs_pkg::RST_TPM_EN)) u_tpm_en (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_board),
        .wr_val   (io_wdata[bp_regs_pkg::BIT_TPM_EN]),
        .bit_q    (tpm_en)
    );

    ctl_bit #(.RST_VAL(bp_regs_pkg::RST_RST_GATE)) u_rst_gate (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (wr_board),
        .wr_val   (io_wdata[bp_regs_pkg::BIT_RST_GATE]),
        .bit_q    (rst_gate)
    );

    // the variant strap is a fixed board level, so the route tracks its
    // synchronised copy from reset release until the first host write to
    // board_control: a front i/o board settles on the extension module
    // once the chain has filled, a rear i/o board stays on rear i/o
    // limitation: for about five cycles after release a front board
    // still shows the rear route
    assign strap_hold_d = strap_load_q & ~wr_board;
    assign serial_rt_d = wr_board
        ? io_wdata[bp_regs_pkg::BIT_SERIAL_RT]
        : (strap_load_q ? front_io_sync : serial_rt_q);

    // backplane reset only passes in a peripheral slot with gate open;
    // a system-slot board owns the backplane reset and must ignore it
    assign board_rst_d = ~bp_rst_n_sync & slot_kind_flag & rst_gate;

    // register images; unused bits stay zero
    // status bits are the synchronised pin levels, never the raw pins
    assign status_byte = {
        bus_speed_flag,
        3'h0,
        slot_kind_flag,
        hot_swap_event_flag,
        supply_fail_flag,
        supply_derate_flag
    };

    assign general_byte = {video_mode_field_q, flash_sel, 5'h00};

    assign board_byte = {
        sata_run,
        igfx_enabled,
        tpm_en,
        rst_gate,
        1'h0,
        serial_rt_q,
        2'h0
    };

    assign rdata_d = hit_status  ? status_byte  :
                     hit_general ? general_byte :
                     hit_board   ? board_byte   : 8'h00;

    // control state
    // video mode lives here because its two bits share one write strobe
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            video_mode_field_q <= bp_regs_pkg::RST_VIDEO_MODE;
            serial_rt_q        <= bp_regs_pkg::RST_SERIAL_RT;
        end else begin
            video_mode_field_q <= video_mode_d;
            serial_rt_q        <= serial_rt_d;
        end
    end

    // strap tracking ends at the first host write to board_control, so a
    // later strap glitch can never undo a route the host has chosen
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strap_load_q <= 1'h1;
        end else begin
            strap_load_q <= strap_hold_d;
        end
    end

    // read port
    // ack answers every read, hit only reads inside the bank; data holds
    // its last value so a slow host may pick it up after the ack
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_rdata_q  <= 8'h00;
            io_rd_ack_q <= 1'h0;
            io_rd_hit_q <= 1'h0;
        end else begin
            io_rd_ack_q <= io_rd_en;
            io_rd_hit_q <= io_rd_en & hit_any;
            if (io_rd_en) begin
                io_rdata_q <= rdata_d;
            end
        end
    end

    // outputs straight from flops
    // one cycle of extra lag buys glitch-free control pins off the board
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            update_flash_select_q  <= bp_regs_pkg::RST_FLASH_SEL;
            sata_module_run_q      <= bp_regs_pkg::RST_SATA_RUN;
            tpm_enable_q           <= bp_regs_pkg::RST_TPM_EN;
            backplane_reset_gate_q <= bp_regs_pkg::RST_RST_GATE;
            serial_route_select_q  <= bp_regs_pkg::RST_SERIAL_RT;
            board_reset_req_q      <= 1'h0;
        end else begin
            update_flash_select_q  <= flash_sel;
            sata_module_run_q      <= sata_run;
            tpm_enable_q           <= tpm_en;
            backplane_reset_gate_q <= rst_gate;
            serial_route_select_q  <= serial_rt_q;
            board_reset_req_q      <= board_rst_d;
        end
    end

endmodule : backplane_status_board_control_regs
`default_nettype wire

/* File: sim/bp_regs_chk_monitor.sv */
// Purpose: port checker for the backplane register bank
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the bank by the statement after the module
`timescale 1ns/1ps
`default_nettype none
module bp_regs_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // host access
    input wire logic [15:0] io_addr,
    input wire logic        io_rd_en,
    input wire logic        io_wr_en,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata_q,
    input wire logic        io_rd_ack_q,
    input wire logic        io_rd_hit_q,
    // control outputs
    input wire logic [1:0]  video_mode_field_q,
    input wire logic        update_flash_select_q,
    input wire logic        sata_module_run_q,
    input wire logic        tpm_enable_q,
    input wire logic        backplane_reset_gate_q,
    input wire logic        serial_route_select_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic in_map = io_addr inside {[16'h0281:16'h0283]};
    wire logic rd_st  = io_rd_en && io_addr == 16'h0281;
    wire logic rd_gc  = io_rd_en && io_addr == 16'h0282;
    wire logic rd_bc  = io_rd_en && io_addr == 16'h0283;
    wire logic wr_gc  = io_wr_en && io_addr == 16'h0282;
    wire logic wr_bc  = io_wr_en && io_addr == 16'h0283;
    // write data one and two cycles back, for the delayed outputs
    logic [7:0] wd1_q;
    logic [7:0] wd2_q;
    always_ff @(posedge core_clk) begin
        wd1_q <= io_wdata;
        wd2_q <= wd1_q;
    end
    unmapped_rd_a: assert property (io_rd_en && !in_map |=> io_rd_ack_q
        && !io_rd_hit_q && io_rdata_q == 8'h00) else $error("unmapped read");
    stat_resv_a: assert property (rd_st |=> io_rd_hit_q
        && io_rdata_q[6:4] == 3'h0) else $error("status reserved bits");
    gen_resv_a: assert property (rd_gc |=> io_rdata_q[4:0] == 5'h00)
        else $error("general reserved bits");
    brd_resv_a: assert property (rd_bc |=> io_rdata_q[3] == 1'b0
        && io_rdata_q[1:0] == 2'h0) else $error("board reserved bits");
    video_wr_a: assert property (wr_gc |=> video_mode_field_q == wd1_q[7:6])
        else $error("video mode not written");
    flash_wr_a: assert property (wr_gc |-> ##2
        update_flash_select_q == wd2_q[5]) else $error("flash select");
    sata_tpm_a: assert property (wr_bc |-> ##2 sata_module_run_q == wd2_q[7]
        && tpm_enable_q == wd2_q[5]) else $error("sata or tpm control");
    gate_route_a: assert property (wr_bc |-> ##2
        backplane_reset_gate_q == wd2_q[4] && serial_route_select_q == wd2_q[2])
        else $error("gate or serial route");
    reset_vals_a: assert property ($rose(rst_n) |-> video_mode_field_q == 2'h1
        && !update_flash_select_q && tpm_enable_q) else $error("reset values");
    brd_back_a: assert property (wr_bc ##1 rd_bc |=> io_rdata_q[7] == wd2_q[7]
        && io_rdata_q[5:4] == wd2_q[5:4] && io_rdata_q[2] == wd2_q[2])
        else $error("board readback");
    cover property (rd_bc ##1 io_rd_hit_q);
    cover property (wr_gc ##1 rd_gc);
    cover property (io_rd_en && !in_map);
endmodule : bp_regs_chk
bind backplane_status_board_control_regs bp_regs_chk chk_u (
    .core_clk, .rst_n, .io_addr, .io_rd_en, .io_wr_en, .io_wdata,
    .io_rdata_q, .io_rd_ack_q, .io_rd_hit_q, .video_mode_field_q,
    .update_flash_select_q, .sata_module_run_q, .tpm_enable_q,
    .backplane_reset_gate_q, .serial_route_select_q
);
`default_nettype wire

/* File: sim/backplane_model.sv */
// Purpose: backplane side of the board, driving the slot signals
// Assumes: levels are asynchronous to core_clk
// Notes:   bits are speed, slot, hot swap, fail, derate, reset_n
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
    // clock
    input  wire logic       core_clk,
    // requested levels
    input  wire logic [5:0] want,
    // backplane pins
    output var  logic [5:0] pins
);
    initial pins = 6'h3f;
    // moves after the falling edge so a change lands mid-cycle
    always @(negedge core_clk) pins <= want;
endmodule : backplane_model
`default_nettype wire

/* File: sim/test_backplane_status_board_control_regs.sv */
// Purpose: self-checking bench for the backplane register bank
// Assumes: read answer one cycle after the strobe
// Notes:   pin changes get six cycles to cross the synchronisers
`timescale 1ns/1ps
`default_nettype none
module test_backplane_status_board_control_regs;
    logic        core_clk;
    logic        rst_n;
    logic [15:0] io_addr;
    logic        io_rd_en;
    logic        io_wr_en;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata_q;
    logic        io_rd_ack_q;
    logic        io_rd_hit_q;
    logic [5:0]  want;
    logic [5:0]  pins;
    logic        front_io;
    logic        igfx_pin;
    logic [1:0]  video_q;
    logic        flash_q, sata_q, tpm_q, gate_q, serial_q, req_q;
    logic [7:0]  rv;
    logic [7:0]  d;
    int          err_total;
    int          tests_run;

    backplane_model bp_u (.core_clk(core_clk), .want(want), .pins(pins));
    backplane_status_board_control_regs dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
        .io_rd_en(io_rd_en), .io_wr_en(io_wr_en), .io_wdata(io_wdata),
        .io_rdata_q(io_rdata_q), .io_rd_ack_q(io_rd_ack_q),
        .io_rd_hit_q(io_rd_hit_q), .bus_speed_pin(pins[5]),
        .slot_kind_pin(pins[4]), .hot_swap_event_pin(pins[3]),
        .supply_fail_pin(pins[2]), .supply_derate_pin(pins[1]),
        .backplane_rst_pin_n(pins[0]), .front_io_variant(front_io),
        .igfx_enabled_pin(igfx_pin), .video_mode_field_q(video_q),
        .update_flash_select_q(flash_q), .sata_module_run_q(sata_q),
        .tpm_enable_q(tpm_q), .backplane_reset_gate_q(gate_q),
        .serial_route_select_q(serial_q), .board_reset_req_q(req_q));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [7:0] st_exp(input logic [5:0] w);
        return {w[5], 3'h0, w[4:1]};
    endfunction : st_exp
    function automatic logic [7:0] bc_exp(input logic [7:0] v, input logic g);
        return {v[7], g, v[5:4], 1'b0, v[2], 2'h0};
    endfunction : bc_exp

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // no idle after a write, so a read may follow at once; never wr twice
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        io_addr = a;
        io_wdata = v;
        io_wr_en = 1'b1;
        @(negedge core_clk);
        io_wr_en = 1'b0;
        io_wdata = ~v;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic h, output logic [7:0] v);
        io_addr = a;
        io_rd_en = 1'b1;
        @(negedge core_clk);
        io_rd_en = 1'b0;
        check({7'h0, io_rd_ack_q}, 8'h01);
        check({7'h0, io_rd_hit_q}, {7'h0, h});
        v = io_rdata_q;
        @(negedge core_clk);
    endtask : rd

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end

    initial begin
        want = 6'h3f;
        front_io = 1'b0;
        igfx_pin = 1'b1;
        io_addr = 16'h0000;
        io_rd_en = 1'b0;
        io_wr_en = 1'b0;
        io_wdata = 8'h00;
        rst_n = 1'b0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(32'haf5c6234));
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        rd(16'h0282, 1'b1, rv);
        check(rv, 8'h40);
        rd(16'h0283, 1'b1, rv);
        check(rv, 8'hf0);
        for (int i = 0; i < 10; i++) begin
            want = (i < 2) ? {6{i[0]}} : 6'($urandom);
            want[0] = 1'b1;
            repeat (6) @(negedge core_clk);
            rd(16'h0281, 1'b1, rv);
            check(rv, st_exp(want));
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[7:6] = i[1:0];
            wr(16'h0282, d);
            rd(16'h0282, 1'b1, rv);
            check(rv, d & 8'he0);
            check({6'h0, video_q, flash_q}, {6'h0, d[7:5]});
        end
        for (int i = 0; i < 12; i++) begin
            d = (i < 2) ? {8{i[0]}} : 8'($urandom);
            igfx_pin = 1'($urandom);
            repeat (6) @(negedge core_clk);
            wr(16'h0283, d);
            rd(16'h0283, 1'b1, rv);
            check(rv, bc_exp(d, igfx_pin));
            check({sata_q, tpm_q, gate_q, serial_q}, {d[7], d[5:4], d[2]});
        end
        wr(16'h0281, 8'h70);
        rd(16'h0280, 1'b0, rv);
        check(rv, 8'h00);
        wr(16'h0284, 8'hff);
        rd(16'h0281, 1'b1, rv);
        check(rv, st_exp(want));
        // backplane reset only reaches the board through an open gate
        wr(16'h0283, 8'h10);
        want = 6'h1e;
        repeat (8) @(negedge core_clk);
        check({7'h0, req_q}, 8'h01);
        wr(16'h0283, 8'h00);
        repeat (8) @(negedge core_clk);
        check({7'h0, req_q}, 8'h00);
        want = 6'h0e;
        wr(16'h0283, 8'h10);
        repeat (8) @(negedge core_clk);
        check({7'h0, req_q}, 8'h00);
        // second reset as a front i/o board: route defaults to extension
        front_io = 1'b1;
        igfx_pin = 1'b1;
        rst_n = 1'b0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (6) @(negedge core_clk);
        rd(16'h0283, 1'b1, rv);
        check(rv, 8'hf4);
        check({7'h0, serial_q}, 8'h01);
        wr(16'h0283, 8'h00);
        rd(16'h0283, 1'b1, rv);
        check(rv, 8'h40);
        give_verdict();
    end
endmodule : test_backplane_status_board_control_regs
`default_nettype wire
